// ==== hw/dsi_lane_pkg.sv ====
// constants, state encodings and lane codes for the serial display lane receiver
// assumes a single system clock domain; lane pins arrive asynchronously
package dsi_lane_pkg;

  // single-ended lane state codes, {positive line, negative line}
  localparam logic [1:0] LP_00 = 2'h0;
  localparam logic [1:0] LP_01 = 2'h1;
  localparam logic [1:0] LP_10 = 2'h2;
  localparam logic [1:0] LP_11 = 2'h3;

  // documented lane counts
  localparam int DATA_LANES = 4;

  // reset values of the sampled pins: lines idle high, differential bit low
  localparam logic LINE_RESET = 1'b1;
  localparam logic HS_BIT_RESET = 1'b0;
  localparam logic [1:0] LP_CODE_RESET = LP_11;

  // toggles seen after HS-0 before the clock counts as running
  localparam int HS_EDGES_TO_RUN = 2;
  localparam int HS_EDGE_CNT_W = 3;

  // clock lane tracker states, gray along both entry paths
  typedef enum logic [2:0] {
    CK_LPM = 3'h0,
    CK_HS_REQ = 3'h1,
    CK_HS_BRIDGE = 3'h3,
    CK_HIGH_SPEED_CLOCK_RUNNING_MODE = 3'h2,
    CK_ULP_REQ = 3'h4,
    CK_CLOCK_LANE_ULTRA_LOW_POWER_MODE = 3'h5,
    CK_ULP_EXIT = 3'h7
  } clk_state_e;

  // clock lane power modes as reported outward
  typedef enum logic [1:0] {
    MODE_LPM = 2'h0,
    MODE_CLOCK_LANE_ULTRA_LOW_POWER_MODE = 2'h1,
    MODE_HIGH_SPEED_CLOCK_RUNNING_MODE = 2'h2
  } clk_mode_e;

  // data lane control states
  typedef enum logic [2:0] {
    DL_STOP = 3'h0,
    DL_HS_REQ = 3'h1,
    DL_SETTLE = 3'h3,
    DL_HS = 3'h2,
    DL_WAIT_STOP = 3'h6
  } data_state_e;

endpackage

// ==== hw/dsi_lane_rx_top.sv ====
// lane state logic of the serial display receiver: clock lane mode tracker,
// per data lane control state, termination control and lane 0 reverse drive
// assumes the link clock toggles no faster than a quarter of the system clock
`timescale 1ns/1ps
module dsi_lane_rx_top #(
  parameter int DATA_LANES = dsi_lane_pkg::DATA_LANES, // number of data lanes
  parameter int HS_EDGES_TO_RUN = dsi_lane_pkg::HS_EDGES_TO_RUN // toggles to call clock running
) (
  input wire logic CLK_SYS_I, // system clock, 50 MHz
  input wire logic RESETN_I, // async reset, active low
  input wire logic CLK_LANE_P_I, // clock lane positive line, low-power rx
  input wire logic CLK_LANE_N_I, // clock lane negative line, low-power rx
  input wire logic CLK_LANE_HS_I, // clock lane differential rx output
  input wire logic [DATA_LANES-1:0] DATA_LANE_P_I, // data lane positive lines
  input wire logic [DATA_LANES-1:0] DATA_LANE_N_I, // data lane negative lines
  input wire logic [DATA_LANES-1:0] DATA_LANE_HS_I, // data lane differential rx outputs
  input wire logic LANE0_TX_EN_I, // request to drive data lane 0
  input wire logic LANE0_TX_P_I, // level for lane 0 positive line
  input wire logic LANE0_TX_N_I, // level for lane 0 negative line
  output logic [1:0] CLK_MODE_O, // clock lane power mode
  output logic CLK_HS_RUNNING_O, // high-speed clock seen running
  output logic CLK_TERM_EN_O, // clock lane termination and diff rx enable
  output logic [1:0] CLK_LP_STATE_O, // clock lane single-ended state code
  output logic [2*DATA_LANES-1:0] DATA_LP_STATE_O, // data lane state codes, lane 0 low
  output logic [DATA_LANES-1:0] DATA_TERM_EN_O, // data lane termination and diff rx enable
  output logic [DATA_LANES-1:0] DATA_HS_ACTIVE_O, // data lane in high-speed reception
  output logic [DATA_LANES-1:0] DATA_HS_BIT_O, // received high-speed bit per lane
  output logic LANE0_P_O, // lane 0 positive line drive level
  output logic LANE0_P_OE_O, // lane 0 positive line drive enable
  output logic LANE0_N_O, // lane 0 negative line drive level
  output logic LANE0_N_OE_O // lane 0 negative line drive enable
);

  // data lane control step, shared by every data lane
  function automatic dsi_lane_pkg::data_state_e data_step(
    input dsi_lane_pkg::data_state_e cur,
    input logic [1:0] code,
    input logic hs_bit,
    input logic clk_running
  );
    dsi_lane_pkg::data_state_e nxt;
    nxt = cur;
    if (code == dsi_lane_pkg::LP_11) begin
      nxt = dsi_lane_pkg::DL_STOP;
    end else begin
      case (cur)
        dsi_lane_pkg::DL_STOP: begin
          if (code == dsi_lane_pkg::LP_01) begin
            nxt = dsi_lane_pkg::DL_HS_REQ;
          end else if (code == dsi_lane_pkg::LP_10) begin
            nxt = dsi_lane_pkg::DL_WAIT_STOP;
          end
        end
        dsi_lane_pkg::DL_HS_REQ: begin
          // a burst without a running clock cannot be received at all
          if (code == dsi_lane_pkg::LP_00 && clk_running) begin
            nxt = dsi_lane_pkg::DL_SETTLE;
          end else if (code != dsi_lane_pkg::LP_01) begin
            nxt = dsi_lane_pkg::DL_WAIT_STOP;
          end
        end
        dsi_lane_pkg::DL_SETTLE: begin
          if (!hs_bit) begin
            nxt = dsi_lane_pkg::DL_HS;
          end
        end
        dsi_lane_pkg::DL_HS: begin
          nxt = dsi_lane_pkg::DL_HS;
        end
        dsi_lane_pkg::DL_WAIT_STOP: begin
          nxt = dsi_lane_pkg::DL_WAIT_STOP;
        end
        default: begin
          nxt = dsi_lane_pkg::DL_STOP;
        end
      endcase
    end
    return nxt;
  endfunction

  // termination belongs to the high-speed states only
  function automatic logic data_term(input dsi_lane_pkg::data_state_e st);
    return (st == dsi_lane_pkg::DL_SETTLE) || (st == dsi_lane_pkg::DL_HS);
  endfunction

  logic [1:0] clk_code;
  logic clk_hs_bit;
  logic clk_hs_edge;
  logic [1:0] data_code [DATA_LANES];
  logic [DATA_LANES-1:0] data_hs_bit;

  // clock lane front end
  dsi_lane_sampler clk_sampler (
    .clk_i(CLK_SYS_I),
    .rst_n_i(RESETN_I),
    .line_p_i(CLK_LANE_P_I),
    .line_n_i(CLK_LANE_N_I),
    .hs_diff_i(CLK_LANE_HS_I),
    .lp_code_o(clk_code),
    .hs_bit_o(clk_hs_bit),
    .hs_edge_o(clk_hs_edge)
  );

  // ---- clock lane tracker ----
  dsi_lane_pkg::clk_state_e clk_state;
  dsi_lane_pkg::clk_state_e next_clk_state;
  logic seen_hs0;
  logic next_seen_hs0;
  logic [dsi_lane_pkg::HS_EDGE_CNT_W-1:0] edge_cnt;
  logic [dsi_lane_pkg::HS_EDGE_CNT_W-1:0] next_edge_cnt;
  logic hs_running;
  logic next_hs_running;

  localparam logic [dsi_lane_pkg::HS_EDGE_CNT_W-1:0] EDGE_TARGET =
    dsi_lane_pkg::HS_EDGE_CNT_W'(HS_EDGES_TO_RUN);

  // mode changes on single-ended codes, except bridge to running, which waits on the toggle count; the differential bit is
  // consulted only once termination is on in the bridge state
  always_comb begin
    next_clk_state = clk_state;
    next_seen_hs0 = seen_hs0;
    next_edge_cnt = edge_cnt;
    next_hs_running = hs_running;
    case (clk_state)
      dsi_lane_pkg::CK_LPM: begin
        next_seen_hs0 = 1'b0;
        next_edge_cnt = '0;
        next_hs_running = 1'b0;
        if (clk_code == dsi_lane_pkg::LP_10) begin
          next_clk_state = dsi_lane_pkg::CK_ULP_REQ;
        end else if (clk_code == dsi_lane_pkg::LP_01) begin
          next_clk_state = dsi_lane_pkg::CK_HS_REQ;
        end
      end
      dsi_lane_pkg::CK_ULP_REQ: begin
        if (clk_code == dsi_lane_pkg::LP_00) begin
          next_clk_state = dsi_lane_pkg::CK_CLOCK_LANE_ULTRA_LOW_POWER_MODE;
        end else if (clk_code != dsi_lane_pkg::LP_10) begin
          next_clk_state = dsi_lane_pkg::CK_LPM;
        end
      end
      dsi_lane_pkg::CK_CLOCK_LANE_ULTRA_LOW_POWER_MODE: begin
        if (clk_code == dsi_lane_pkg::LP_10) begin
          next_clk_state = dsi_lane_pkg::CK_ULP_EXIT;
        end else if (clk_code == dsi_lane_pkg::LP_11) begin
          next_clk_state = dsi_lane_pkg::CK_LPM;
        end
      end
      dsi_lane_pkg::CK_ULP_EXIT: begin
        if (clk_code == dsi_lane_pkg::LP_11) begin
          next_clk_state = dsi_lane_pkg::CK_LPM;
        end else if (clk_code != dsi_lane_pkg::LP_10) begin
          next_clk_state = dsi_lane_pkg::CK_CLOCK_LANE_ULTRA_LOW_POWER_MODE;
        end
      end
      dsi_lane_pkg::CK_HS_REQ: begin
        if (clk_code == dsi_lane_pkg::LP_00) begin
          next_clk_state = dsi_lane_pkg::CK_HS_BRIDGE;
        end else if (clk_code != dsi_lane_pkg::LP_01) begin
          next_clk_state = dsi_lane_pkg::CK_LPM;
        end
      end
      dsi_lane_pkg::CK_HS_BRIDGE: begin
        // toggles count only after HS-0 has been seen, so noise on an
        // undriven pair before settling does not start the clock
        if (clk_code == dsi_lane_pkg::LP_11) begin
          next_clk_state = dsi_lane_pkg::CK_LPM;
        end else begin
          if (!clk_hs_bit) begin
            next_seen_hs0 = 1'b1;
          end
          if (seen_hs0 && clk_hs_edge) begin
            next_edge_cnt = edge_cnt + 1'b1;
          end
          if (edge_cnt >= EDGE_TARGET) begin
            next_clk_state = dsi_lane_pkg::CK_HIGH_SPEED_CLOCK_RUNNING_MODE;
            next_hs_running = 1'b1;
          end
        end
      end
      dsi_lane_pkg::CK_HIGH_SPEED_CLOCK_RUNNING_MODE: begin
        // the host ends on HS-0 before stop; only the stop code is watched
        if (clk_code == dsi_lane_pkg::LP_11) begin
          next_clk_state = dsi_lane_pkg::CK_LPM;
          next_hs_running = 1'b0;
        end
      end
      default: begin
        next_clk_state = dsi_lane_pkg::CK_LPM;
        next_hs_running = 1'b0;
      end
    endcase
  end

  // reset lands in low-power mode with the lines idle at stop
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      clk_state <= dsi_lane_pkg::CK_LPM;
      seen_hs0 <= 1'b0;
      edge_cnt <= '0;
      hs_running <= 1'b0;
    end else begin
      clk_state <= next_clk_state;
      seen_hs0 <= next_seen_hs0;
      edge_cnt <= next_edge_cnt;
      hs_running <= next_hs_running;
    end
  end

  // mode seen from outside; request and bridge states still count as
  // low-power until the new mode is actually reached
  always_comb begin
    case (clk_state)
      dsi_lane_pkg::CK_CLOCK_LANE_ULTRA_LOW_POWER_MODE, dsi_lane_pkg::CK_ULP_EXIT: begin
        CLK_MODE_O = dsi_lane_pkg::MODE_CLOCK_LANE_ULTRA_LOW_POWER_MODE;
      end
      dsi_lane_pkg::CK_HIGH_SPEED_CLOCK_RUNNING_MODE: begin
        CLK_MODE_O = dsi_lane_pkg::MODE_HIGH_SPEED_CLOCK_RUNNING_MODE;
      end
      default: begin
        CLK_MODE_O = dsi_lane_pkg::MODE_LPM;
      end
    endcase
  end

  assign CLK_HS_RUNNING_O = hs_running;
  assign CLK_TERM_EN_O = (clk_state == dsi_lane_pkg::CK_HS_BRIDGE) ||
                         (clk_state == dsi_lane_pkg::CK_HIGH_SPEED_CLOCK_RUNNING_MODE);
  assign CLK_LP_STATE_O = clk_code;

  // ---- data lanes ----
  dsi_lane_pkg::data_state_e data_state [DATA_LANES];
  logic lane0_drive;

  genvar g;
  generate
    for (g = 0; g < DATA_LANES; g++) begin : gen_lane
      dsi_lane_pkg::data_state_e next_state;
      logic hs_reg;
      logic next_hs_reg;
      logic hold;

      dsi_lane_sampler sampler (
        .clk_i(CLK_SYS_I),
        .rst_n_i(RESETN_I),
        .line_p_i(DATA_LANE_P_I[g]),
        .line_n_i(DATA_LANE_N_I[g]),
        .hs_diff_i(DATA_LANE_HS_I[g]),
        .lp_code_o(data_code[g]),
        .hs_bit_o(data_hs_bit[g]),
        .hs_edge_o() // data lanes need no toggle pulse
      );

      // lane 0 ignores its own drive while it holds the line
      if (g == 0) begin : gen_hold
        assign hold = lane0_drive;
      end else begin : gen_nohold
        assign hold = 1'b0;
      end

      // escape and turnaround codes are only waited out here: lanes 1-3
      // never answer, so no low-power payload is ever taken on them
      always_comb begin
        next_state = hold ? data_state[g] :
          data_step(data_state[g], data_code[g], data_hs_bit[g], hs_running);
        next_hs_reg = (data_state[g] == dsi_lane_pkg::DL_HS) ? data_hs_bit[g] : 1'b0;
      end

      always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
          data_state[g] <= dsi_lane_pkg::DL_STOP;
          hs_reg <= 1'b0;
        end else begin
          data_state[g] <= next_state;
          hs_reg <= next_hs_reg;
        end
      end

      assign DATA_LP_STATE_O[2*g +: 2] = data_code[g];
      assign DATA_TERM_EN_O[g] = data_term(data_state[g]);
      assign DATA_HS_ACTIVE_O[g] = (data_state[g] == dsi_lane_pkg::DL_HS);
      assign DATA_HS_BIT_O[g] = hs_reg;
    end
  endgenerate

  // ---- lane 0 reverse drive ----
  logic next_lane0_drive;
  logic lane0_p;
  logic lane0_n;
  logic next_lane0_p;
  logic next_lane0_n;

  // drive is taken only from stop, so it never fights a host burst;
  // once driving it lasts as long as the request stays high
  always_comb begin
    next_lane0_drive = LANE0_TX_EN_I &&
      (lane0_drive || data_state[0] == dsi_lane_pkg::DL_STOP);
    next_lane0_p = next_lane0_drive ? LANE0_TX_P_I : 1'b0;
    next_lane0_n = next_lane0_drive ? LANE0_TX_N_I : 1'b0;
  end

  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      lane0_drive <= 1'b0;
      lane0_p <= 1'b0;
      lane0_n <= 1'b0;
    end else begin
      lane0_drive <= next_lane0_drive;
      lane0_p <= next_lane0_p;
      lane0_n <= next_lane0_n;
    end
  end

  assign LANE0_P_O = lane0_p;
  assign LANE0_N_O = lane0_n;
  assign LANE0_P_OE_O = lane0_drive;
  assign LANE0_N_OE_O = lane0_drive;

endmodule

// ==== hw/dsi_lane_sampler.sv ====
// one lane pair front end: two-flop synchronisers and a stable state code
// assumes raw pin levels from the low-power and differential receivers
`timescale 1ns/1ps
module dsi_lane_sampler (
  input wire logic clk_i, // system clock
  input wire logic rst_n_i, // async reset, active low
  input wire logic line_p_i, // positive line, low-power receiver
  input wire logic line_n_i, // negative line, low-power receiver
  input wire logic hs_diff_i, // differential receiver output
  output logic [1:0] lp_code_o, // stable single-ended state code
  output logic hs_bit_o, // synchronised differential bit
  output logic hs_edge_o // pulse on each differential toggle
);

  logic [2:0] meta;
  logic [2:0] sync;
  logic [1:0] prev_lp;
  logic [1:0] lp_code;
  logic hs_bit;
  logic hs_prev;
  logic [2:0] next_meta;
  logic [2:0] next_sync;
  logic [1:0] next_prev_lp;
  logic [1:0] next_lp_code;
  logic next_hs_bit;
  logic next_hs_prev;

  // code only moves after two equal samples, so a skewed line pair
  // crossing through 00 or 11 for one sample is not taken as a state
  always_comb begin
    next_meta = {line_p_i, line_n_i, hs_diff_i};
    next_sync = meta;
    next_prev_lp = sync[2:1];
    next_lp_code = (sync[2:1] == prev_lp) ? prev_lp : lp_code;
    next_hs_bit = sync[0];
    next_hs_prev = hs_bit;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta <= {dsi_lane_pkg::LINE_RESET, dsi_lane_pkg::LINE_RESET, dsi_lane_pkg::HS_BIT_RESET};
      sync <= {dsi_lane_pkg::LINE_RESET, dsi_lane_pkg::LINE_RESET, dsi_lane_pkg::HS_BIT_RESET};
      prev_lp <= dsi_lane_pkg::LP_CODE_RESET;
      lp_code <= dsi_lane_pkg::LP_CODE_RESET;
      hs_bit <= dsi_lane_pkg::HS_BIT_RESET;
      hs_prev <= dsi_lane_pkg::HS_BIT_RESET;
    end else begin
      meta <= next_meta;
      sync <= next_sync;
      prev_lp <= next_prev_lp;
      lp_code <= next_lp_code;
      hs_bit <= next_hs_bit;
      hs_prev <= next_hs_prev;
    end
  end

  assign lp_code_o = lp_code;
  assign hs_bit_o = hs_bit;
  assign hs_edge_o = hs_bit ^ hs_prev;

endmodule

// ==== sim/dsi_host_model.sv ====
// behavioural host driving the clock lane and four data lanes
// assumes the system clock for timing; link clock period 160 ns
`timescale 1ns/1ps
module dsi_host_model (
  input wire logic clk_i, // system clock, timing only
  input wire logic [1:0] ck_code_i, // clock lane code {p, n} to drive
  input wire logic ck_run_i, // toggle the clock pair as a running hs clock
  input wire logic [7:0] d_code_i, // data lane codes, lane 0 low
  input wire logic d_hs_sel_i, // data pairs carry hs bits
  input wire logic [3:0] d_hs_i, // hs bit per data lane
  output logic ck_p_o, // clock lane positive line
  output logic ck_n_o, // clock lane negative line
  output logic ck_hs_o, // clock lane differential level
  output logic [3:0] d_p_o, // data positive lines
  output logic [3:0] d_n_o, // data negative lines
  output logic [3:0] d_hs_o // data differential levels
);
  logic tog = 1'b0;
  // half period of 80 ns while the burst runs; a stopped clock falls
  // back to the line code, so the pair ends on HS-0 while lines are low
  always begin
    wait (ck_run_i);
    repeat (4) @(posedge clk_i);
    #1;
    if (ck_run_i) tog = ~tog;
    else tog = 1'b0;
  end
  // in low power the diff receiver just follows the positive line
  assign ck_p_o = ck_code_i[1];
  assign ck_n_o = ck_code_i[0];
  assign ck_hs_o = ck_run_i ? tog : ck_code_i[1];
  always_comb begin
    for (int g = 0; g < 4; g++) begin
      d_p_o[g] = d_code_i[2*g+1];
      d_n_o[g] = d_code_i[2*g];
      d_hs_o[g] = d_hs_sel_i ? d_hs_i[g] : d_code_i[2*g+1];
    end
  end
endmodule

// ==== sim/dsi_lane_rx_asserts.sv ====
// concurrent checks on the lane receiver top ports
// assumes one clock domain and the async active-low reset
`timescale 1ns/1ps
module dsi_lane_rx_asserts #(
  parameter int DATA_LANES = 4, // lanes watched
  parameter int HS_EDGES_TO_RUN = 2 // toggles before running
) (
  input wire logic CLK_SYS_I, // system clock
  input wire logic RESETN_I, // async reset, active low
  input wire logic LANE0_TX_EN_I, // lane 0 drive request
  input wire logic LANE0_TX_P_I, // lane 0 positive level
  input wire logic [1:0] CLK_MODE_O, // clock lane mode
  input wire logic CLK_HS_RUNNING_O, // clock running
  input wire logic CLK_TERM_EN_O, // clock termination
  input wire logic [1:0] CLK_LP_STATE_O, // clock lane code
  input wire logic [2*DATA_LANES-1:0] DATA_LP_STATE_O, // data codes
  input wire logic [DATA_LANES-1:0] DATA_TERM_EN_O, // data termination
  input wire logic [DATA_LANES-1:0] DATA_HS_ACTIVE_O, // data in hs
  input wire logic LANE0_P_O, // lane 0 positive drive
  input wire logic LANE0_P_OE_O, // lane 0 positive enable
  input wire logic LANE0_N_OE_O // lane 0 negative enable
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESETN_I);
  // bridge: termination up while the mode still reads low power
  sequence s_bridge;
    CLK_TERM_EN_O && CLK_MODE_O == dsi_lane_pkg::MODE_LPM;
  endsequence
  a_mode_legal: assert property (CLK_MODE_O != 2'h3)
    else $error("unused clock mode code");
  a_run_high_speed_clock_running_mode: assert property (CLK_HS_RUNNING_O == (CLK_MODE_O == dsi_lane_pkg::MODE_HIGH_SPEED_CLOCK_RUNNING_MODE))
    else $error("running flag and mode disagree");
  a_clock_lane_ultra_low_power_mode_term_off: assert property (CLK_MODE_O == dsi_lane_pkg::MODE_CLOCK_LANE_ULTRA_LOW_POWER_MODE |-> !CLK_TERM_EN_O)
    else $error("termination on in ultra low power");
  a_term_at_bridge: assert property ($rose(CLK_TERM_EN_O) |-> s_bridge ##0
    CLK_LP_STATE_O == dsi_lane_pkg::LP_00) else $error("termination rose outside bridge");
  a_high_speed_clock_running_mode_entry: assert property ($rose(CLK_HS_RUNNING_O) |-> $past(CLK_TERM_EN_O))
    else $error("clock ran without bridge");
  a_clock_lane_ultra_low_power_mode_entry: assert property ($changed(CLK_MODE_O) && CLK_MODE_O == dsi_lane_pkg::MODE_CLOCK_LANE_ULTRA_LOW_POWER_MODE
    |-> $past(CLK_LP_STATE_O) == dsi_lane_pkg::LP_00) else $error("clock_lane_ultra_low_power_mode without lp-00");
  a_lpm_needs_stop: assert property ($changed(CLK_MODE_O) && CLK_MODE_O == 2'h0
    |-> $past(CLK_LP_STATE_O) == dsi_lane_pkg::LP_11) else $error("lpm without lp-11");
  a_clock_lane_ultra_low_power_mode_hold: assert property (CLK_MODE_O == dsi_lane_pkg::MODE_CLOCK_LANE_ULTRA_LOW_POWER_MODE && !CLK_LP_STATE_O[1]
    |=> CLK_MODE_O == dsi_lane_pkg::MODE_CLOCK_LANE_ULTRA_LOW_POWER_MODE) else $error("clock_lane_ultra_low_power_mode left on bad code");
  a_hs_term: assert property ((DATA_HS_ACTIVE_O & ~DATA_TERM_EN_O) == '0)
    else $error("hs lane without termination");
  a_lane0_release: assert property (!LANE0_TX_EN_I |=> !LANE0_P_OE_O && !LANE0_N_OE_O)
    else $error("lane 0 still driven");
  a_lane0_level: assert property (LANE0_P_OE_O |-> LANE0_P_O == $past(LANE0_TX_P_I))
    else $error("lane 0 level wrong");
  // one stop check per data lane
  for (genvar g = 0; g < DATA_LANES; g++) begin : g_lane
    a_data_stop: assert property (DATA_LP_STATE_O[2*g+:2] == 2'h3 |=> !DATA_TERM_EN_O[g])
      else $error("data termination kept at stop");
  end
endmodule
bind dsi_lane_rx_top dsi_lane_rx_asserts #(.DATA_LANES(DATA_LANES),
  .HS_EDGES_TO_RUN(HS_EDGES_TO_RUN)) u_chk (.CLK_SYS_I(CLK_SYS_I), .RESETN_I(RESETN_I),
  .LANE0_TX_EN_I(LANE0_TX_EN_I), .LANE0_TX_P_I(LANE0_TX_P_I), .CLK_MODE_O(CLK_MODE_O),
  .CLK_HS_RUNNING_O(CLK_HS_RUNNING_O), .CLK_TERM_EN_O(CLK_TERM_EN_O),
  .CLK_LP_STATE_O(CLK_LP_STATE_O), .DATA_LP_STATE_O(DATA_LP_STATE_O),
  .DATA_TERM_EN_O(DATA_TERM_EN_O), .DATA_HS_ACTIVE_O(DATA_HS_ACTIVE_O),
  .LANE0_P_O(LANE0_P_O), .LANE0_P_OE_O(LANE0_P_OE_O), .LANE0_N_OE_O(LANE0_N_OE_O));

// ==== sim/dsi_lane_rx_top_test.sv ====
// self-checking bench for the lane receiver, host model on the far side
// assumes 50 MHz system clock and the model's 160 ns link clock
`timescale 1ns/1ps
module dsi_lane_rx_top_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic tx_en = 1'b0;
  logic tx_p = 1'b0;
  logic tx_n = 1'b0;
  logic ck_p, ck_n, ck_hs, running, ck_term, l0_p, l0_poe, l0_n, l0_noe;
  logic [1:0] mode, ck_st;
  logic [3:0] d_p, d_n, d_hs, d_term, d_act, d_bit, lane_p, lane_n;
  logic [7:0] d_st;
  logic [7:0] v;
  logic [1:0] ck_code = 2'h3;
  logic ck_go = 1'b0;
  logic [7:0] d_code = 8'hff;
  logic d_sel = 1'b0;
  logic [3:0] d_bits = 4'h0;
  int failures = 0;
  int check_count = 0;
  // only lane 0 is two-way; the other lanes have no drive path
  assign lane_p = {d_p[3:1], l0_poe ? l0_p : d_p[0]};
  assign lane_n = {d_n[3:1], l0_noe ? l0_n : d_n[0]};
  initial begin
    forever #10 clk = ~clk;
  end
  dsi_host_model host (.clk_i(clk), .ck_code_i(ck_code), .ck_run_i(ck_go), .d_code_i(d_code),
    .d_hs_sel_i(d_sel), .d_hs_i(d_bits), .ck_p_o(ck_p), .ck_n_o(ck_n), .ck_hs_o(ck_hs),
    .d_p_o(d_p), .d_n_o(d_n), .d_hs_o(d_hs));
  dsi_lane_rx_top #(.DATA_LANES(4), .HS_EDGES_TO_RUN(2)) dut (.CLK_SYS_I(clk),
    .RESETN_I(rst_n), .CLK_LANE_P_I(ck_p), .CLK_LANE_N_I(ck_n), .CLK_LANE_HS_I(ck_hs),
    .DATA_LANE_P_I(lane_p), .DATA_LANE_N_I(lane_n), .DATA_LANE_HS_I(d_hs),
    .LANE0_TX_EN_I(tx_en), .LANE0_TX_P_I(tx_p), .LANE0_TX_N_I(tx_n), .CLK_MODE_O(mode),
    .CLK_HS_RUNNING_O(running), .CLK_TERM_EN_O(ck_term), .CLK_LP_STATE_O(ck_st),
    .DATA_LP_STATE_O(d_st), .DATA_TERM_EN_O(d_term), .DATA_HS_ACTIVE_O(d_act),
    .DATA_HS_BIT_O(d_bit), .LANE0_P_O(l0_p), .LANE0_P_OE_O(l0_poe), .LANE0_N_O(l0_n),
    .LANE0_N_OE_O(l0_noe));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // hold each code 8 cycles, twice the receiver filter
  task automatic ck_lp(input logic [1:0] c);
    ck_code = c;
    step(8);
  endtask
  task automatic d_lp(input logic [7:0] c);
    d_sel = 1'b0;
    d_code = c;
    step(8);
  endtask
  // clock settles on HS-0 before it toggles, and runs before any data
  task automatic ck_run();
    step(8);
    ck_go = 1'b1;
    step(40);
  endtask
  // data lanes are back at stop already; last bit HS-0, then stop
  task automatic ck_stop();
    ck_go = 1'b0;
    step(9);
    ck_lp(dsi_lane_pkg::LP_11);
  endtask
  // pixel data only ever go out as hs bits
  task automatic hs_data(input logic [3:0] b);
    d_sel = 1'b1;
    d_bits = b;
    step(8);
  endtask
  task automatic t_idle();
    chk(mode, dsi_lane_pkg::MODE_LPM);
    chk(ck_st, dsi_lane_pkg::LP_11);
    chk({running, ck_term, d_term, l0_poe, l0_noe}, 8'h00);
    chk(d_st, 8'hff);
  endtask
  // each lane shows a different code per pass; no hs without a clock
  task automatic t_decode();
    for (int c = 0; c < 4; c++) begin
      for (int g = 0; g < 4; g++) v[2*g+:2] = 2'(c + g);
      d_lp(v);
      chk(d_st, v);
      chk({d_term, d_act}, 8'h00);
    end
    d_lp(8'hff);
    d_lp(8'h55);
    d_lp(8'h00);
    chk({d_term, d_act}, 8'h00);
    d_lp(8'hff);
  endtask
  task automatic t_clock_lane_ultra_low_power_mode();
    ck_lp(dsi_lane_pkg::LP_10);
    ck_lp(dsi_lane_pkg::LP_01);
    chk(mode, dsi_lane_pkg::MODE_LPM);
    ck_lp(dsi_lane_pkg::LP_11);
    ck_lp(dsi_lane_pkg::LP_10);
    chk(mode, dsi_lane_pkg::MODE_LPM);
    ck_lp(dsi_lane_pkg::LP_00);
    chk({ck_term, mode}, dsi_lane_pkg::MODE_CLOCK_LANE_ULTRA_LOW_POWER_MODE);
    ck_lp(dsi_lane_pkg::LP_10);
    ck_lp(dsi_lane_pkg::LP_01);
    ck_lp(dsi_lane_pkg::LP_00);
    chk(mode, dsi_lane_pkg::MODE_CLOCK_LANE_ULTRA_LOW_POWER_MODE);
    ck_lp(dsi_lane_pkg::LP_10);
    chk(mode, dsi_lane_pkg::MODE_CLOCK_LANE_ULTRA_LOW_POWER_MODE);
    ck_lp(dsi_lane_pkg::LP_11);
    chk(mode, dsi_lane_pkg::MODE_LPM);
  endtask
  // clock burst wraps the data burst on both ends
  task automatic t_high_speed_clock_running_mode();
    ck_lp(dsi_lane_pkg::LP_01);
    chk(ck_term, 1'b0);
    ck_lp(dsi_lane_pkg::LP_00);
    chk({ck_term, mode}, 8'h04);
    ck_run();
    chk({running, mode}, 8'h06);
    chk(ck_st, dsi_lane_pkg::LP_00);
    d_lp(8'h55);
    d_lp(8'h00);
    chk(d_term, 4'hf);
    hs_data(4'ha);
    chk({d_act, d_bit}, 8'hfa);
    hs_data(4'h5);
    chk(d_bit, 4'h5);
    d_lp(8'hff);
    chk({d_act, d_term}, 8'h00);
    chk(mode, dsi_lane_pkg::MODE_HIGH_SPEED_CLOCK_RUNNING_MODE);
    ck_stop();
    chk({running, ck_term, mode}, 8'h00);
  endtask
  task automatic t_lane0();
    {tx_en, tx_p, tx_n} = 3'h6;
    step(4);
    chk({l0_poe, l0_noe, l0_p, l0_n}, 8'h0e);
    {tx_p, tx_n} = 2'h1;
    step(2);
    chk({l0_p, l0_n}, 8'h01);
    tx_en = 1'b0;
    step(2);
    chk({l0_poe, l0_noe}, 8'h00);
    step(8);
  endtask
  // stop straight out of ultra low power, then reset in mid-run from
  // ultra low power with the lines still low
  task automatic t_rst_mid();
    ck_lp(dsi_lane_pkg::LP_10);
    ck_lp(dsi_lane_pkg::LP_00);
    ck_lp(dsi_lane_pkg::LP_11);
    chk(mode, dsi_lane_pkg::MODE_LPM);
    ck_lp(dsi_lane_pkg::LP_10);
    ck_lp(dsi_lane_pkg::LP_00);
    chk(mode, dsi_lane_pkg::MODE_CLOCK_LANE_ULTRA_LOW_POWER_MODE);
    rst_n = 1'b0;
    step(2);
    t_idle();
    rst_n = 1'b1;
    ck_lp(dsi_lane_pkg::LP_11);
    chk(mode, dsi_lane_pkg::MODE_LPM);
  endtask
  task automatic results();
    if (failures == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    #1;
    rst_n = 1'b1;
    step(2);
    t_idle();
    t_decode();
    t_clock_lane_ultra_low_power_mode();
    t_high_speed_clock_running_mode();
    t_lane0();
    t_rst_mid();
    results();
  end
  // tests need about 340 cycles; this is far beyond
  initial begin
    #200us;
    failures++;
    results();
  end
endmodule
